// ### inc/acc_defs.vh
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH
// register byte offsets
`define ACC_OFF_SEL      12'h000
`define ACC_OFF_INWORD   12'h004
`define ACC_OFF_GRPWORD  12'h008
`define ACC_OFF_COMMIT   12'h00c
`define ACC_OFF_STATUS   12'h010
`define ACC_OFF_MASK     12'h014
`define ACC_OFF_FIELD    12'h018
`define ACC_OFF_CHSTATE  12'h01c
`define ACC_OFF_COUNT    12'h020
`define ACC_OFF_UNIT     12'h024
// parameter word digit positions (4-bit digits)
`define ACC_IN_DLY_LSB   12
`define ACC_IN_RST_LSB   8
`define ACC_IN_TYPE_LSB  4
`define ACC_IN_IND_LSB   0
`define ACC_IN_PUMP_LSB  16
`define ACC_GRP_A_LSB    8
`define ACC_GRP_B_LSB    0
// input type codes
`define ACC_T_NO         3'h0
`define ACC_T_NC         3'h1
`define ACC_T_RISE       3'h2
`define ACC_T_FALL       3'h3
`define ACC_T_BOTH       3'h4
`define ACC_T_CNT_CL     3'h5
`define ACC_T_CNT_OP     3'h6
`define ACC_T_CNT_BO     3'h7
// indication codes
`define ACC_IND_NORM     4'h0
`define ACC_IND_RING     4'h1
`define ACC_IND_FOLLOW   4'h2
// reflash group codes
`define ACC_GRP_1        8'h01
`define ACC_GRP_2        8'h02
// reset values
`define ACC_IN_RST_VAL   24'h000000
`define ACC_GRP_RST_VAL  16'h0000
// timing: one-minute window at 125 MHz
`define ACC_CLK_HZ       125000000
`define ACC_MINUTE_S     60
// 125e6 * 60 needs 33 bits; a 32-bit product would wrap
`define ACC_MINUTE_CYC   33'd7500000000
`endif

// ### design/acc_chan.v
`include "acc_defs.vh"
module acc_chan (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // field input and timing
   input  wire        field_in,
   input  wire        minute_tick,
   // committed configuration
   input  wire [2:0]  in_type,
   input  wire [7:0]  pump_lim,
   // results
   output reg         alarm_q,
   output reg         event_q,
   output reg         pumping_q,
   output reg  [15:0] count_q
);
   reg       prev_q;
   reg [7:0] rate_q;
   wire rise = field_in & ~prev_q;
   wire fall = ~field_in & prev_q;
   reg  qual;
   always @* begin
      case (in_type)
         `ACC_T_RISE, `ACC_T_CNT_CL: qual = rise;
         `ACC_T_FALL, `ACC_T_CNT_OP: qual = fall;
         `ACC_T_BOTH, `ACC_T_CNT_BO: qual = rise | fall;
         default:                    qual = rise | fall;
      endcase
   end
   wire counting = in_type[2] & (in_type != `ACC_T_BOTH);
   wire edge_mode = (in_type == `ACC_T_RISE) | (in_type == `ACC_T_FALL) |
                    (in_type == `ACC_T_BOTH);
   // level modes: closed contact is field_in high
   wire lvl = (in_type == `ACC_T_NC) ? ~field_in : field_in;
   wire sup_on = (pump_lim != 8'h00);
   // limit reached: hold off further events until window restarts
   wire over = sup_on & (rate_q >= pump_lim);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q    <= 1'b0;
         rate_q    <= 8'h00;
         alarm_q   <= 1'b0;
         event_q   <= 1'b0;
         pumping_q <= 1'b0;
         count_q   <= 16'h0000;
      end else begin
         prev_q  <= field_in;
         event_q <= 1'b0;
         if (minute_tick) begin
            rate_q    <= 8'h00;
            pumping_q <= 1'b0;
         end
         if (counting) begin
            alarm_q <= 1'b0;
            if (qual && !over)
               count_q <= count_q + 16'h0001;
         end else if (edge_mode) begin
            alarm_q <= 1'b0;
            if (qual && !over) begin
               alarm_q <= 1'b1;
               event_q <= 1'b1;
            end
         end else begin
            if (lvl != alarm_q && !(lvl && over)) begin
               alarm_q <= lvl;
               event_q <= lvl;
            end
         end
         if (!minute_tick && sup_on) begin
            if ((counting | edge_mode) ? qual : (lvl & ~alarm_q)) begin
               if (over)
                  pumping_q <= 1'b1;
               else
                  rate_q <= rate_q + 8'h01;
            end
         end
      end
   end
endmodule

// ### design/acc_top.v
`include "acc_defs.vh"
module acc_top #(
   parameter [32:0] MINUTE_CYC = `ACC_MINUTE_CYC
) (
   // apb
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // field contacts
   input  wire [15:0] field_in,
   // unit sequence and interlock in
   input  wire [2:0]  unit_seq,
   input  wire [15:0] lock_in,
   // annunciator outputs
   output reg  [15:0] lamp_q,
   output reg         horn_q,
   output reg  [15:0] lock_out_q,
   output reg  [1:0]  reflash_a_q,
   output reg  [1:0]  reflash_b_q,
   output reg         irq_q
);
   // staged values, committed per channel into the parameter store
   reg  [3:0]  sel_q;
   reg  [23:0] in_stage_q;
   reg  [15:0] grp_stage_q;
   reg  [23:0] in_mem   [0:15];
   reg  [15:0] grp_mem  [0:15];
   reg  [15:0] status_q;
   reg  [15:0] mask_q;
   reg  [32:0] min_cnt_q;
   reg         tick_q;
   reg  [15:0] ring_q;
   wire [15:0] alarm;
   wire [15:0] event_p;
   wire [15:0] pump;
   wire [15:0] cnt [0:15];
   wire [15:0] horn_v;
   wire [1:0]  ra_v [0:15];
   wire [1:0]  rb_v [0:15];
   // writes land at the edge that completes the access
   wire        wr  = psel & penable & pwrite & pready;
   wire        rd  = psel & penable & ~pwrite & ~pready;
   wire        acc = psel & penable & ~pready;
   wire        mapped = (paddr[1:0] == 2'b00) && (paddr <= `ACC_OFF_UNIT);
   wire        commit = wr && paddr == `ACC_OFF_COMMIT && pwdata[0];
   wire        ring_seq = (unit_seq == 3'h3) | (unit_seq == 3'h4);

   genvar g;
   generate
      for (g = 0; g < 16; g = g + 1) begin : ch
         wire [23:0] w   = in_mem[g];
         wire [15:0] gw  = grp_mem[g];
         wire [2:0]  ty  = w[`ACC_IN_TYPE_LSB +: 3];
         wire [3:0]  ind = w[`ACC_IN_IND_LSB +: 4];
         wire [7:0]  pm  = w[`ACC_IN_PUMP_LSB +: 8];
         wire [7:0]  ga  = gw[`ACC_GRP_A_LSB +: 8];
         wire [7:0]  gb  = gw[`ACC_GRP_B_LSB +: 8];
         wire        edg = (ty == `ACC_T_RISE) | (ty == `ACC_T_FALL) |
                           (ty == `ACC_T_BOTH);
         acc_chan u_chan (
            .pclk        (pclk),
            .presetn     (presetn),
            .field_in    (field_in[g]),
            .minute_tick (tick_q),
            .in_type     (ty),
            .pump_lim    (pm),
            .alarm_q     (alarm[g]),
            .event_q     (event_p[g]),
            .pumping_q   (pump[g]),
            .count_q     (cnt[g])
         );
         // follow mode never sounds the horn
         assign horn_v[g] = (ind != `ACC_IND_FOLLOW) &
                            (alarm[g] | ring_q[g]);
         // each reflash type drives its own group
         assign ra_v[g] = {ga == `ACC_GRP_2, ga == `ACC_GRP_1} &
                          {2{event_p[g]}};
         assign rb_v[g] = {gb == `ACC_GRP_2, gb == `ACC_GRP_1} &
                          {2{event_p[g]}};
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               lamp_q[g]     <= 1'b0;
               lock_out_q[g] <= 1'b0;
               ring_q[g]     <= 1'b0;
            end else begin
               if (ind == `ACC_IND_FOLLOW)
                  lamp_q[g] <= field_in[g];
               else
                  lamp_q[g] <= (alarm[g] | ring_q[g]) & ~lock_in[g];
               // ringback on return to normal, sequences 3 and 4 only
               if (ind == `ACC_IND_RING && ring_seq && !edg &&
                   alarm[g] && !field_lvl(ty, field_in[g]))
                  ring_q[g] <= 1'b1;
               else if (alarm[g] || ind != `ACC_IND_RING)
                  ring_q[g] <= 1'b0;
               lock_out_q[g] <= alarm[g] & ~edg;
            end
         end
      end
   endgenerate

   function field_lvl;
      input [2:0] t;
      input       f;
      begin
         field_lvl = (t == `ACC_T_NC) ? ~f : f;
      end
   endfunction

   integer i;
   reg [1:0] ra_or;
   reg [1:0] rb_or;
   always @* begin
      ra_or = 2'b00;
      rb_or = 2'b00;
      for (i = 0; i < 16; i = i + 1) begin
         ra_or = ra_or | ra_v[i];
         rb_or = rb_or | rb_v[i];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (i = 0; i < 16; i = i + 1) begin
            in_mem[i]  <= `ACC_IN_RST_VAL;
            grp_mem[i] <= `ACC_GRP_RST_VAL;
         end
      end else if (commit) begin
         // staged value only reaches the store on commit
         in_mem[sel_q]  <= in_stage_q;
         grp_mem[sel_q] <= grp_stage_q;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         min_cnt_q <= 33'h000000000;
         tick_q    <= 1'b0;
      end else if (min_cnt_q >= MINUTE_CYC - 33'h000000001) begin
         min_cnt_q <= 33'h000000000;
         tick_q    <= 1'b1;
      end else begin
         min_cnt_q <= min_cnt_q + 33'h000000001;
         tick_q    <= 1'b0;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q       <= 4'h0;
         in_stage_q  <= `ACC_IN_RST_VAL;
         grp_stage_q <= `ACC_GRP_RST_VAL;
         mask_q      <= 16'h0000;
         status_q    <= 16'h0000;
         prdata      <= 32'h00000000;
         pready      <= 1'b0;
         pslverr     <= 1'b0;
         horn_q      <= 1'b0;
         reflash_a_q <= 2'b00;
         reflash_b_q <= 2'b00;
         irq_q       <= 1'b0;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= 1'b0;
         // new events win over a same-cycle clear
         status_q <= (status_q & ~((wr && paddr == `ACC_OFF_STATUS) ?
                     pwdata[15:0] : 16'h0000)) | event_p | pump;
         irq_q       <= |((status_q | event_p | pump) & mask_q);
         horn_q      <= |horn_v;
         reflash_a_q <= ra_or;
         reflash_b_q <= rb_or;
         // error decided a cycle early so it stands with pready
         if (acc && !mapped)
            pslverr <= 1'b1;
         if (wr) begin
            case (paddr)
               `ACC_OFF_SEL:     sel_q       <= pwdata[3:0];
               `ACC_OFF_INWORD:  in_stage_q  <= pwdata[23:0];
               `ACC_OFF_GRPWORD: grp_stage_q <= pwdata[15:0];
               `ACC_OFF_MASK:    mask_q      <= pwdata[15:0];
               `ACC_OFF_COMMIT, `ACC_OFF_STATUS: ;
               default:          ;
            endcase
         end
         if (rd) begin
            case (paddr)
               `ACC_OFF_SEL:     prdata <= {28'h0, sel_q};
               `ACC_OFF_INWORD:  prdata <= {8'h00, in_mem[sel_q]};
               `ACC_OFF_GRPWORD: prdata <= {16'h0000, grp_mem[sel_q]};
               `ACC_OFF_COMMIT:  prdata <= 32'h00000000;
               `ACC_OFF_STATUS:  prdata <= {16'h0000, status_q};
               `ACC_OFF_MASK:    prdata <= {16'h0000, mask_q};
               `ACC_OFF_FIELD:   prdata <= {16'h0000, field_in};
               `ACC_OFF_CHSTATE: prdata <= {pump, alarm};
               `ACC_OFF_COUNT:   prdata <= {16'h0000, cnt[sel_q]};
               `ACC_OFF_UNIT:    prdata <= {29'h0, unit_seq};
               default: begin
                  prdata  <= 32'h00000000;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule

// ### tb/acc_props.sv
module acc_props (
   // clock and reset
   input logic        pclk,
   input logic        presetn,
   // apb
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   // outputs quiet after reset
   input logic [15:0] lamp_q,
   input logic        horn_q,
   input logic        irq_q
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // a stuck pready would complete two transfers
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_ready_wait: assert property ($rose(penable) && psel |=> pready)
      else $error("pready not one cycle after access");
   a_ready_cause: assert property (!(psel && penable) |=> !pready)
      else $error("pready without access");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_err_unmapped: assert property ($rose(penable) && psel &&
      paddr > 12'h024 |=> pslverr) else $error("unmapped not refused");
   a_ok_mapped: assert property ($rose(penable) && psel &&
      paddr <= 12'h024 && paddr[1:0] == 2'b00 |=> !pslverr)
      else $error("mapped access refused");
   a_err_rd_zero: assert property ($rose(penable) && psel && !pwrite &&
      paddr > 12'h024 |=> prdata == 32'h0) else $error("bad read data");
   a_field_upper: assert property ($rose(penable) && psel && !pwrite &&
      paddr == 12'h018 |=> prdata[31:16] == 16'h0)
      else $error("field read upper bits set");
   a_reset_quiet: assert property ($rose(presetn) |->
      lamp_q == 16'h0 && !horn_q && !irq_q) else $error("busy after reset");
   c_write: cover property (psel && penable && pready && pwrite);
   c_read: cover property (psel && penable && pready && !pwrite);
   c_error: cover property (pready && pslverr);
endmodule

bind acc_top acc_props u_props (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .prdata, .pready, .pslverr, .lamp_q, .horn_q, .irq_q);

// ### tb/acc_field.sv
module acc_field (
   // clock
   input  logic        pclk,
   // contact positions asked for by the bench
   input  logic [15:0] want,
   // contact levels, high = closed
   output logic [15:0] field_in = 16'h0000
);
   timeunit 1ns;
   timeprecision 1ps;
   // contacts settle one clock after being moved, never glitch between
   always @(posedge pclk) field_in <= want;
endmodule

// ### tb/tb_top.sv
`include "acc_defs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q, c0;
   logic        pready, pslverr, horn_q, irq_q, se, hn_seen = 0;
   logic [15:0] fld = 16'h0, field_in, lamp_q, lock_out_q, lk_seen = 0;
   logic [1:0]  ra, rb, ra_seen = 0, rb_seen = 0;
   int          err_count = 0, total_checks = 0, t, cyc = 0;
   // short window keeps the pumping scenario brief
   acc_top #(.MINUTE_CYC(33'd400)) u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .field_in(field_in), .unit_seq(3'h3),
      .lock_in(16'h0), .lamp_q(lamp_q), .horn_q(horn_q),
      .lock_out_q(lock_out_q), .reflash_a_q(ra), .reflash_b_q(rb),
      .irq_q(irq_q));
   acc_field u_field (.pclk(pclk), .want(fld), .field_in(field_in));
   always #4 pclk = ~pclk;
   // pulses are short, so remember every one seen
   always @(posedge pclk) begin
      hn_seen <= hn_seen | horn_q;
      lk_seen <= lk_seen | lock_out_q;
      ra_seen <= ra_seen | ra;
      rb_seen <= rb_seen | rb;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         test_done;
      end
   end
   task test_done;
      if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input [31:0] g, input [31:0] e);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %0t: got %h exp %h", $time, g, e);
      end
   endtask
   // hold the request until pready is sampled high at a rising edge
   task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] r);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      se = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task wr(input [11:0] a, input [31:0] d);
      xfer(1, a, d, q);
   endtask
   task rdm(input [11:0] a, input [31:0] m, input [31:0] e);
      xfer(0, a, 32'h0, q);
      chk(q & m, e);
   endtask
   task sf(input [15:0] v);
      @(posedge pclk);
      fld <= v;
      repeat (4) @(posedge pclk);
   endtask
   function [31:0] mk(input [2:0] ty, input [3:0] i, input [7:0] p);
      mk = {8'h00, p, 9'h000, ty, i};
   endfunction
   task cfg(input [3:0] c, input [31:0] w, input [15:0] g);
      wr(`ACC_OFF_SEL, {28'h0, c});
      wr(`ACC_OFF_INWORD, w);
      wr(`ACC_OFF_GRPWORD, {16'h0, g});
      wr(`ACC_OFF_COMMIT, 32'h1);
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      cfg(6, mk(`ACC_T_NO, `ACC_IND_FOLLOW, 8'h0), 16'h0);
      sf(16'h0040);
      chk(lamp_q[6], 1);
      sf(16'h0000);
      chk({lamp_q[6], hn_seen}, 0);
      wr(`ACC_OFF_SEL, 32'h2);
      rdm(`ACC_OFF_INWORD, '1, 32'h0);
      wr(`ACC_OFF_INWORD, mk(3'h6, 4'h1, 8'h63));
      wr(`ACC_OFF_GRPWORD, 32'h0102);
      rdm(`ACC_OFF_INWORD, '1, 32'h0);
      wr(`ACC_OFF_COMMIT, 32'h1);
      rdm(`ACC_OFF_INWORD, '1, mk(3'h6, 4'h1, 8'h63));
      rdm(`ACC_OFF_GRPWORD, '1, 32'h0102);
      cfg(0, mk(`ACC_T_NO, `ACC_IND_NORM, 8'h0), 16'h0);
      cfg(1, mk(`ACC_T_NC, `ACC_IND_NORM, 8'h0), 16'h0);
      sf(16'h0001);
      rdm(`ACC_OFF_CHSTATE, 32'h3, 32'h3);
      chk(lock_out_q[0], 1);
      sf(16'h0002);
      rdm(`ACC_OFF_CHSTATE, 32'h3, 32'h0);
      wr(`ACC_OFF_MASK, 32'h10);
      for (t = 2; t < 5; t++) begin
         cfg(4, mk(t[2:0], 4'h0, 8'h0), 16'h0102);
         wr(`ACC_OFF_STATUS, 32'hffff);
         sf(16'h0012);
         rdm(`ACC_OFF_STATUS, 32'h10, {t != 3, 4'h0});
         chk(irq_q, t != 3);
         wr(`ACC_OFF_STATUS, 32'h10);
         sf(16'h0002);
         rdm(`ACC_OFF_STATUS, 32'h10, {t != 2, 4'h0});
      end
      wr(`ACC_OFF_MASK, 32'h0);
      // irq follows the mask one edge after the write completes
      repeat (2) @(posedge pclk);
      chk(irq_q, 0);
      chk(lk_seen[4], 0);
      chk({rb_seen, ra_seen}, 4'b1001);
      for (t = 5; t < 8; t++) begin
         cfg(5, mk(t[2:0], 4'h0, 8'h0), 16'h0);
         xfer(0, `ACC_OFF_COUNT, 32'h0, c0);
         repeat (3) begin
            sf(16'h0022);
            sf(16'h0002);
         end
         rdm(`ACC_OFF_COUNT, '1, c0 + (t == 7 ? 6 : 3));
      end
      cfg(8, mk(`ACC_T_BOTH, 4'h0, 8'h2), 16'h0);
      cfg(9, mk(`ACC_T_BOTH, 4'h0, 8'h0), 16'h0);
      // start just after a window restart so no tick splits the burst
      while (cyc % 400 != 20) @(posedge pclk);
      repeat (2) begin
         sf(16'h0302);
         sf(16'h0002);
      end
      rdm(`ACC_OFF_CHSTATE, 32'h0300_0000, 32'h0100_0000);
      repeat (450) @(posedge pclk);
      rdm(`ACC_OFF_CHSTATE, 32'h0100_0000, 32'h0);
      xfer(0, 12'h030, 32'h0, q);
      chk(q, 0);
      chk(se, 1);
      test_done;
   end
endmodule
